// ---- design/acl_key_pkg.sv ----
// bit positions and constants of the second-stage acl lookup keys
package acl_key_pkg;
  localparam int KEY_W       = 188;
  localparam int COMMON_W    = 46;
  // ipv4 transport and ipv4 other keys
  localparam int P_IS_IPV4   = 46;
  localparam int P_FRAG      = 47;
  localparam int P_NONFIRST  = 48;
  localparam int P_OPTIONS   = 49;
  localparam int P_TTL       = 50;
  localparam int P_TOS       = 51;
  localparam int P_DST4      = 59;
  localparam int P_SRC4      = 91;
  localparam int P_ADDR_EQ   = 123;
  localparam int P_TCP       = 124;
  localparam int P_DPORT     = 125;
  localparam int P_SPORT     = 141;
  localparam int P_RANGE     = 157;
  localparam int P_PORTS_EQ  = 165;
  localparam int P_SEQ0      = 166;
  localparam int P_FIN       = 167;
  localparam int P_SYN       = 168;
  localparam int P_RST       = 169;
  localparam int P_PSH       = 170;
  localparam int P_ACK       = 171;
  localparam int P_URG       = 172;
  localparam int P_PTP_DOM   = 173;
  localparam int P_PTP_VER   = 181;
  localparam int L4_LO       = 125;
  localparam int L4_W        = 60;
  localparam int P_PROTO     = 124;
  localparam int P_PAYLOAD   = 132;
  // standard ipv6 key
  localparam int P6_TTL      = 46;
  localparam int P6_SRC      = 47;
  localparam int P6_PROTO    = 175;
  // oam key
  localparam int P_DMAC      = 46;
  localparam int P_SMAC      = 94;
  localparam int P_MEL       = 142;
  localparam int MEL_W       = 7;
  localparam int P_OAM_VERSION_FIELD   = 149;
  localparam int P_OPCODE    = 154;
  localparam int P_OFLAGS    = 162;
  localparam int P_MEPID     = 170;
  localparam int P_CNTS0     = 186;
  localparam int P_OAM_ET    = 187;
  // header constants
  localparam logic [15:0] OAM_ETHERTYPE = 16'h8902;
  localparam logic [7:0]  TCP_PROTO     = 8'h06;
  localparam logic [3:0]  IHL_MIN       = 4'h5;
  localparam logic [6:0]  MEL_ALL       = 7'h7F;
  typedef enum logic [1:0] {
    KT_TRANSPORT = 2'b00,
    KT_OTHER     = 2'b01,
    KT_V6STD     = 2'b10,
    KT_OAM       = 2'b11
  } key_type_e;
endpackage

// ---- design/ip_header_flags.sv ----
// fragment, options, ttl and address-equality flags of an ip header
`timescale 1ns/1ps
module ip_header_flags (
  // header fields
  input  wire logic         is_ipv6,
  input  wire logic         more_fragments,
  input  wire logic [12:0]  frag_offset,
  input  wire logic [3:0]   header_len,
  input  wire logic [7:0]   ttl,
  input  wire logic [127:0] src_addr,
  input  wire logic [127:0] dst_addr,
  // flags
  output logic              ip_fragmented,
  output logic              non_first_fragment,
  output logic              ip_options_present,
  output logic              ttl_nonzero,
  output logic              ip_src_equals_dst
);
  always_comb begin
    ip_fragmented      = more_fragments || (frag_offset != 13'h0000);
    non_first_fragment = (frag_offset != 13'h0000);
    ip_options_present = !is_ipv6 && (header_len > acl_key_pkg::IHL_MIN);
    ttl_nonzero        = (ttl != 8'h00);
    if (is_ipv6) begin
      ip_src_equals_dst = (src_addr == dst_addr);
    end else begin
      ip_src_equals_dst = (src_addr[31:0] == dst_addr[31:0]);
    end
  end
endmodule // ip_header_flags

// ---- design/acl_key_field_builder.sv ----
// builds one second-stage acl lookup key with its care mask per request
//
// What this block does
// - bits 166-172 tcp seq-zero and flags or ptp bits
// - ptp domain at bit 173
// - ptp version at bit 181
// - options or later fragment: layer-4 don't-care
// - bit 46 set for ipv4 frames
// - bit 47 set when fragmented
// - bit 48 set for non-first fragment
// - bit 49 set when ipv4 header length above 5
// - bit 50 ttl nonzero, tos at 51
// - addresses at 59 and 91, ipv6 source low half in both
// - bit 123 full source/destination equality
// - protocol at 124, payload at 132
// - ipv6 key bit 46 hop limit nonzero
// - ipv6 source at 47, next header 175
// - oam key mac addresses at 46, 94
// - maintenance level thermometer code at 142
// - oam version, opcode, flags, endpoint id
// - bit 186 when loss counters zero
// - bit 187 when ethertype is oam
`timescale 1ns/1ps
module acl_key_field_builder (
  // clock and reset
  input  wire logic         CLK,
  input  wire logic         RESET_N,
  // request
  input  wire logic         KEY_REQ,
  input  wire logic [1:0]   KEY_TYPE,
  input  wire logic [45:0]  COMMON_FIELDS,
  // layer 3
  input  wire logic         IS_IPV6,
  input  wire logic         MORE_FRAGMENTS,
  input  wire logic [12:0]  FRAG_OFFSET,
  input  wire logic [3:0]   HEADER_LEN,
  input  wire logic [7:0]   TTL,
  input  wire logic [7:0]   TYPE_OF_SERVICE,
  input  wire logic [31:0]  IPV4_SRC_ADDR,
  input  wire logic [31:0]  IPV4_DEST_ADDR,
  input  wire logic [127:0] IPV6_SRC_ADDR,
  input  wire logic [127:0] IPV6_DEST_ADDR,
  input  wire logic [7:0]   IP_PROTOCOL_NUMBER,
  input  wire logic [55:0]  POST_HEADER_BYTES,
  // layer 4
  input  wire logic         IS_PTP,
  input  wire logic [15:0]  TRANSPORT_SRC_PORT,
  input  wire logic [15:0]  TRANSPORT_DST_PORT,
  input  wire logic [7:0]   RANGE_MATCH_MASK,
  input  wire logic         TCP_SEQ_ZERO,
  input  wire logic         TCP_FIN_FLAG,
  input  wire logic         TCP_SYN_FLAG,
  input  wire logic         TCP_RST_FLAG,
  input  wire logic         TCP_PSH_FLAG,
  input  wire logic         TCP_ACK_FLAG,
  input  wire logic         TCP_URG_FLAG,
  input  wire logic [3:0]   PTP_MSG_TYPE,
  input  wire logic [7:0]   PTP_FLAG_FIELD,
  input  wire logic [7:0]   PTP_DOMAIN,
  input  wire logic [3:0]   PTP_VERSION,
  // oam
  input  wire logic [47:0]  DEST_MAC,
  input  wire logic [47:0]  SRC_MAC,
  input  wire logic [15:0]  ETHERTYPE,
  input  wire logic [2:0]   MAINTENANCE_LEVEL,
  input  wire logic [4:0]   OAM_VERSION_FIELD,
  input  wire logic [7:0]   FIELD_A,
  input  wire logic [7:0]   FIELD_B,
  input  wire logic [15:0]  ENDPOINT_IDENTIFIER,
  input  wire logic [31:0]  TX_FRAME_COUNT_FWD,
  input  wire logic [31:0]  RX_FRAME_COUNT_BACK,
  input  wire logic [31:0]  TX_FRAME_COUNT_BACK,
  // key to match array
  output logic              KEY_VALID,
  output logic [1:0]        KEY_TYPE_OUT,
  output logic [187:0]      KEY,
  output logic [187:0]      KEY_MASK
);
  typedef struct packed {
    logic                            valid;
    logic [1:0]                      kind;
    logic [acl_key_pkg::KEY_W-1:0]   key;
    logic [acl_key_pkg::KEY_W-1:0]   care;
  } state_s;

  state_s st_reg;
  state_s st_next;

  logic         frag_w;
  logic         nonfirst_w;
  logic         options_w;
  logic         ttl_w;
  logic         addr_eq_w;
  logic [127:0] src_w;
  logic [127:0] dst_w;
  logic         l4_blank_w;

  // ipv4 addresses sit in the low word so one comparator serves both
  assign src_w = IS_IPV6 ? IPV6_SRC_ADDR : {96'h0, IPV4_SRC_ADDR};
  assign dst_w = IS_IPV6 ? IPV6_DEST_ADDR : {96'h0, IPV4_DEST_ADDR};

  ip_header_flags u_flags (
    .is_ipv6            (IS_IPV6),
    .more_fragments     (MORE_FRAGMENTS),
    .frag_offset        (FRAG_OFFSET),
    .header_len         (HEADER_LEN),
    .ttl                (TTL),
    .src_addr           (src_w),
    .dst_addr           (dst_w),
    .ip_fragmented      (frag_w),
    .non_first_fragment (nonfirst_w),
    .ip_options_present (options_w),
    .ttl_nonzero        (ttl_w),
    .ip_src_equals_dst  (addr_eq_w)
  );

  // no layer-4 header can be trusted
  assign l4_blank_w = options_w || nonfirst_w;

  function automatic logic [6:0] therm(input logic [2:0] lvl);
    therm = acl_key_pkg::MEL_ALL >> (3'd7 - lvl);
  endfunction

  always_comb begin
    st_next       = st_reg;
    // valid only the cycle after a request
    st_next.valid = KEY_REQ;
    if (KEY_REQ) begin
      st_next.kind = KEY_TYPE;
      st_next.key  = '0;
      st_next.care = '0;
      st_next.key[acl_key_pkg::COMMON_W-1:0]  = COMMON_FIELDS;
      st_next.care[acl_key_pkg::COMMON_W-1:0] = '1;
      case (acl_key_pkg::key_type_e'(KEY_TYPE))
        acl_key_pkg::KT_TRANSPORT, acl_key_pkg::KT_OTHER: begin
          // ipv6 may fall back to these keys
          st_next.key[acl_key_pkg::P_IS_IPV4]   = !IS_IPV6;
          st_next.key[acl_key_pkg::P_FRAG]      = frag_w;
          st_next.key[acl_key_pkg::P_NONFIRST]  = nonfirst_w;
          st_next.key[acl_key_pkg::P_OPTIONS]   = options_w;
          st_next.key[acl_key_pkg::P_TTL]       = ttl_w;
          st_next.key[acl_key_pkg::P_TOS +: 8]  = TYPE_OF_SERVICE;
          // ipv6 source halves share the fields
          if (IS_IPV6) begin
            st_next.key[acl_key_pkg::P_DST4 +: 32] = IPV6_SRC_ADDR[63:32];
            st_next.key[acl_key_pkg::P_SRC4 +: 32] = IPV6_SRC_ADDR[31:0];
          end else begin
            st_next.key[acl_key_pkg::P_DST4 +: 32] = IPV4_DEST_ADDR;
            st_next.key[acl_key_pkg::P_SRC4 +: 32] = IPV4_SRC_ADDR;
          end
          st_next.key[acl_key_pkg::P_ADDR_EQ] = addr_eq_w;
          st_next.care[acl_key_pkg::P_IS_IPV4 +: 78] = '1;
          if (KEY_TYPE == acl_key_pkg::KT_OTHER) begin
            // protocol and raw bytes after header
            st_next.key[acl_key_pkg::P_PROTO +: 8]    = IP_PROTOCOL_NUMBER;
            st_next.key[acl_key_pkg::P_PAYLOAD +: 56] = POST_HEADER_BYTES;
            st_next.care[acl_key_pkg::P_PROTO +: 64]  = '1;
          end else begin
            st_next.key[acl_key_pkg::P_TCP]         = (IP_PROTOCOL_NUMBER == acl_key_pkg::TCP_PROTO);
            st_next.care[acl_key_pkg::P_TCP]        = 1'b1;
            st_next.key[acl_key_pkg::P_DPORT +: 16] = TRANSPORT_DST_PORT;
            st_next.key[acl_key_pkg::P_SPORT +: 16] = TRANSPORT_SRC_PORT;
            st_next.key[acl_key_pkg::P_RANGE +: 8]  = RANGE_MATCH_MASK;
            st_next.key[acl_key_pkg::P_PORTS_EQ]    = (TRANSPORT_SRC_PORT == TRANSPORT_DST_PORT);
            if (IS_PTP) begin
              st_next.key[acl_key_pkg::P_SEQ0] = PTP_MSG_TYPE[0];
              st_next.key[acl_key_pkg::P_FIN]  = PTP_MSG_TYPE[1];
              // ptp message type and flag bits
              st_next.key[acl_key_pkg::P_SYN]  = PTP_MSG_TYPE[2];
              st_next.key[acl_key_pkg::P_RST]  = PTP_MSG_TYPE[3];
              st_next.key[acl_key_pkg::P_PSH]  = PTP_FLAG_FIELD[1];
              st_next.key[acl_key_pkg::P_ACK]  = PTP_FLAG_FIELD[2];
              st_next.key[acl_key_pkg::P_URG]  = PTP_FLAG_FIELD[7];
              st_next.key[acl_key_pkg::P_PTP_DOM +: 8] = PTP_DOMAIN;
              st_next.key[acl_key_pkg::P_PTP_VER +: 4] = PTP_VERSION;
            end else begin
              st_next.key[acl_key_pkg::P_SEQ0] = TCP_SEQ_ZERO;
              st_next.key[acl_key_pkg::P_FIN]  = TCP_FIN_FLAG;
              st_next.key[acl_key_pkg::P_SYN]  = TCP_SYN_FLAG;
              st_next.key[acl_key_pkg::P_RST]  = TCP_RST_FLAG;
              st_next.key[acl_key_pkg::P_PSH]  = TCP_PSH_FLAG;
              st_next.key[acl_key_pkg::P_ACK]  = TCP_ACK_FLAG;
              st_next.key[acl_key_pkg::P_URG]  = TCP_URG_FLAG;
            end
            // value zeroed too so masked bits compare clean
            if (l4_blank_w) begin
              st_next.key[acl_key_pkg::L4_LO +: acl_key_pkg::L4_W] = '0;
            end else begin
              st_next.care[acl_key_pkg::L4_LO +: acl_key_pkg::L4_W] = '1;
            end
          end
        end
        acl_key_pkg::KT_V6STD: begin
          st_next.key[acl_key_pkg::P6_TTL]         = ttl_w;
          st_next.key[acl_key_pkg::P6_SRC +: 128]  = IPV6_SRC_ADDR;
          st_next.key[acl_key_pkg::P6_PROTO +: 8]  = IP_PROTOCOL_NUMBER;
          st_next.care[acl_key_pkg::P6_TTL +: 137] = '1;
        end
        acl_key_pkg::KT_OAM: begin
          st_next.key[acl_key_pkg::P_DMAC +: 48] = DEST_MAC;
          st_next.key[acl_key_pkg::P_SMAC +: 48] = SRC_MAC;
          st_next.key[acl_key_pkg::P_MEL +: acl_key_pkg::MEL_W] = therm(MAINTENANCE_LEVEL);
          st_next.key[acl_key_pkg::P_OAM_VERSION_FIELD +: 5] = OAM_VERSION_FIELD;
          st_next.key[acl_key_pkg::P_OPCODE +: 8]  = FIELD_A;
          st_next.key[acl_key_pkg::P_OFLAGS +: 8]  = FIELD_B;
          st_next.key[acl_key_pkg::P_MEPID +: 16]  = ENDPOINT_IDENTIFIER;
          st_next.key[acl_key_pkg::P_CNTS0] = (TX_FRAME_COUNT_FWD == 32'h0000_0000) &&
                                              (RX_FRAME_COUNT_BACK == 32'h0000_0000) &&
                                              (TX_FRAME_COUNT_BACK == 32'h0000_0000);
          st_next.key[acl_key_pkg::P_OAM_ET] = (ETHERTYPE == acl_key_pkg::OAM_ETHERTYPE);
          st_next.care[acl_key_pkg::P_DMAC +: 142] = '1;
        end
        default: begin
          st_next.care = '0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign KEY_VALID    = st_reg.valid;
  assign KEY_TYPE_OUT = st_reg.kind;
  assign KEY          = st_reg.key;
  assign KEY_MASK     = st_reg.care;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  logic req_tr;
  logic req_oam;
  logic req_v4;
  assign req_tr  = KEY_REQ && (KEY_TYPE == acl_key_pkg::KT_TRANSPORT);
  assign req_oam = KEY_REQ && (KEY_TYPE == acl_key_pkg::KT_OAM);
  assign req_v4  = KEY_REQ && !KEY_TYPE[1];
  logic req_oth;
  logic req_v6;
  assign req_oth = KEY_REQ && (KEY_TYPE == acl_key_pkg::KT_OTHER);
  assign req_v6  = KEY_REQ && (KEY_TYPE == acl_key_pkg::KT_V6STD);

  a_key_valid_pulse: assert property (KEY_REQ |=> KEY_VALID ##1 (KEY_VALID == $past(KEY_REQ)))
    else $error("key valid not one cycle after request");
  a_tcp_syn_bit: assert property (req_tr && !l4_blank_w && !IS_PTP |=>
      KEY[acl_key_pkg::P_SYN] == $past(TCP_SYN_FLAG) && KEY[acl_key_pkg::P_URG] == $past(TCP_URG_FLAG))
    else $error("tcp flag bits wrong");
  a_ptp_domain_field: assert property (req_tr && !l4_blank_w && IS_PTP |=>
      KEY[acl_key_pkg::P_PTP_DOM +: 8] == $past(PTP_DOMAIN) && KEY[acl_key_pkg::P_RST] == $past(PTP_MSG_TYPE[3]))
    else $error("ptp domain field wrong");
  a_ptp_version_field: assert property (req_tr && !l4_blank_w && IS_PTP |=>
      KEY[acl_key_pkg::P_PTP_VER +: 4] == $past(PTP_VERSION))
    else $error("ptp version field wrong");
  a_l4_dont_care: assert property (req_tr && l4_blank_w |=>
      KEY_MASK[acl_key_pkg::L4_LO +: acl_key_pkg::L4_W] == '0 && KEY_MASK[acl_key_pkg::P_TCP])
    else $error("layer-4 fields not masked");
  a_ipv4_bit: assert property (req_v4 |=> KEY[acl_key_pkg::P_IS_IPV4] != $past(IS_IPV6))
    else $error("ipv4 bit wrong");
  a_frag_bits: assert property (req_v4 |=> KEY[acl_key_pkg::P_NONFIRST] == ($past(FRAG_OFFSET) != 13'h0000) &&
      KEY[acl_key_pkg::P_FRAG] == ($past(MORE_FRAGMENTS) || $past(FRAG_OFFSET) != 13'h0000))
    else $error("fragment bits wrong");
  a_options_bit: assert property (req_v4 |=>
      KEY[acl_key_pkg::P_OPTIONS] == (!$past(IS_IPV6) && $past(HEADER_LEN) > acl_key_pkg::IHL_MIN))
    else $error("options bit wrong");
  a_addr_equal: assert property (req_v4 && IS_IPV6 |=>
      KEY[acl_key_pkg::P_ADDR_EQ] == ($past(IPV6_SRC_ADDR) == $past(IPV6_DEST_ADDR)))
    else $error("address equality wrong");
  a_mel_thermometer: assert property (req_oam |=>
      $countones(KEY[acl_key_pkg::P_MEL +: acl_key_pkg::MEL_W]) == $past(MAINTENANCE_LEVEL) &&
      KEY[acl_key_pkg::P_MEL +: acl_key_pkg::MEL_W] == 7'((8'h01 << $past(MAINTENANCE_LEVEL)) - 8'h01))
    else $error("maintenance level code wrong");
  a_loss_counters: assert property (req_oam && TX_FRAME_COUNT_FWD != 32'h0000_0000 |=>
      !KEY[acl_key_pkg::P_CNTS0])
    else $error("loss counter flag set with nonzero counter");
  a_oam_ethertype: assert property (req_oam |=>
      KEY[acl_key_pkg::P_OAM_ET] == ($past(ETHERTYPE) == acl_key_pkg::OAM_ETHERTYPE))
    else $error("oam ethertype bit wrong");
  a_nonfirst_bit: assert property (req_v4 |=> KEY[acl_key_pkg::P_NONFIRST] == ($past(FRAG_OFFSET) > 13'h0000))
    else $error("non-first fragment bit wrong");
  a_ttl_tos_fields: assert property (req_v4 |=> KEY[acl_key_pkg::P_TTL] == ($past(TTL) != 8'h00) &&
      KEY[acl_key_pkg::P_TOS +: 8] == $past(TYPE_OF_SERVICE))
    else $error("ttl or tos field wrong");
  a_ipv4_addr_fields: assert property (req_v4 && !IS_IPV6 |=>
      KEY[acl_key_pkg::P_DST4 +: 32] == $past(IPV4_DEST_ADDR) &&
      KEY[acl_key_pkg::P_SRC4 +: 32] == $past(IPV4_SRC_ADDR))
    else $error("ipv4 address fields wrong");
  a_ipv6_addr_halves: assert property (req_v4 && IS_IPV6 |=>
      KEY[acl_key_pkg::P_DST4 +: 32] == $past(IPV6_SRC_ADDR[63:32]) &&
      KEY[acl_key_pkg::P_SRC4 +: 32] == $past(IPV6_SRC_ADDR[31:0]))
    else $error("ipv6 source halves wrong");
  a_v4_addr_equal: assert property (req_v4 && !IS_IPV6 |=>
      KEY[acl_key_pkg::P_ADDR_EQ] == ($past(IPV4_SRC_ADDR) == $past(IPV4_DEST_ADDR)))
    else $error("ipv4 address equality wrong");
  a_other_payload: assert property (req_oth |=> KEY[acl_key_pkg::P_PROTO +: 8] == $past(IP_PROTOCOL_NUMBER) &&
      KEY[acl_key_pkg::P_PAYLOAD +: 56] == $past(POST_HEADER_BYTES))
    else $error("protocol or payload field wrong");
  a_hop_limit_bit: assert property (req_v6 |=> KEY[acl_key_pkg::P6_TTL] == ($past(TTL) != 8'h00))
    else $error("hop limit bit wrong");
  a_v6_source_field: assert property (req_v6 |=> KEY[acl_key_pkg::P6_SRC +: 128] == $past(IPV6_SRC_ADDR) &&
      KEY[acl_key_pkg::P6_PROTO +: 8] == $past(IP_PROTOCOL_NUMBER) && KEY_MASK[acl_key_pkg::P6_TTL +: 137] == '1)
    else $error("ipv6 standard key fields wrong");
  a_oam_mac_fields: assert property (req_oam |=> KEY[acl_key_pkg::P_DMAC +: 48] == $past(DEST_MAC) &&
      KEY[acl_key_pkg::P_SMAC +: 48] == $past(SRC_MAC))
    else $error("oam mac fields wrong");
  a_oam_header_fields: assert property (req_oam |=>
      KEY[acl_key_pkg::P_OAM_VERSION_FIELD +: 5] == $past(OAM_VERSION_FIELD) && KEY[acl_key_pkg::P_OPCODE +: 8] == $past(FIELD_A) &&
      KEY[acl_key_pkg::P_OFLAGS +: 8] == $past(FIELD_B) && KEY[acl_key_pkg::P_MEPID +: 16] == $past(ENDPOINT_IDENTIFIER))
    else $error("oam header fields wrong");
  a_loss_all_zero: assert property (req_oam && TX_FRAME_COUNT_FWD == 32'h0000_0000 &&
      RX_FRAME_COUNT_BACK == 32'h0000_0000 && TX_FRAME_COUNT_BACK == 32'h0000_0000 |=>
      KEY[acl_key_pkg::P_CNTS0])
    else $error("loss counter flag clear with zero counters");
  a_l4_value_zero: assert property (req_tr && l4_blank_w |=> KEY[acl_key_pkg::L4_LO +: acl_key_pkg::L4_W] == '0)
    else $error("masked layer-4 value not zero");
  a_l4_care_kept: assert property (req_tr && !l4_blank_w |=>
      KEY_MASK[acl_key_pkg::L4_LO +: acl_key_pkg::L4_W] == '1)
    else $error("layer-4 fields masked without cause");
  a_common_fields: assert property (KEY_REQ |=>
      KEY[acl_key_pkg::COMMON_W-1:0] == $past(COMMON_FIELDS) && KEY_TYPE_OUT == $past(KEY_TYPE))
    else $error("common fields or key type wrong");
  a_key_holds: assert property (!KEY_REQ |=> $stable(KEY) && $stable(KEY_MASK) && $stable(KEY_TYPE_OUT))
    else $error("key changed without a request");

  c_transport_key: cover property (req_tr && !l4_blank_w ##1 KEY_VALID);
  c_l4_masked: cover property (req_tr && options_w ##1 KEY_VALID);
  c_oam_key: cover property (req_oam && ETHERTYPE == acl_key_pkg::OAM_ETHERTYPE ##1 KEY_VALID);
  c_back_to_back: cover property (KEY_REQ ##1 KEY_REQ ##1 KEY_VALID);
endmodule // acl_key_field_builder

// ---- tb/key_sink.sv ----
// match-array side model: takes every presented key
`timescale 1ns/1ps
module key_sink (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // key from builder
  input  wire logic         key_valid,
  input  wire logic [187:0] key,
  input  wire logic [187:0] key_mask,
  // observed
  output int                key_count,
  output logic [187:0]      last_key
);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      key_count <= 0;
      last_key  <= '0;
    end else if (key_valid === 1'b1) begin
      key_count <= key_count + 1;
      last_key  <= key & key_mask;
    end
  end
endmodule // key_sink

// ---- tb/testbench.sv ----
// directed tests of the acl key builder
`timescale 1ns/1ps
module testbench;
  logic clk = 0, rst_n = 0, req = 0, is_v6 = 0, mf = 0, is_ptp = 0;
  logic seq0 = 0, fin = 0, syn = 0, rst = 0, psh = 0, ack = 0, urg = 0, kv;
  logic [1:0]   ktype = 0, kto;
  logic [45:0]  common = 0;
  logic [12:0]  fofs = 0;
  logic [3:0]   hlen = 4'h5, mtype = 0, pver = 0;
  logic [7:0]   ttl = 0, tos = 0, proto = 0, rng = 0, pflag = 0, pdom = 0, fa = 0, fb = 0;
  logic [31:0]  s4 = 0, d4 = 0, c1 = 0, c2 = 0, c3 = 0;
  logic [127:0] s6 = 0, d6 = 0;
  logic [55:0]  pay = 0;
  logic [15:0]  sp = 0, dp = 0, et = 0, mep = 0;
  logic [47:0]  dmac = 0, smac = 0;
  logic [2:0]   maintenance_level = 0;
  logic [4:0]   over = 0;
  logic [187:0] key, kmask, last_key;
  logic [6:0]   therm;
  logic [2:0]   fexp [4] = '{3'h4, 3'h1, 3'h3, 3'h7};
  logic [3:0]   hl [4] = '{4'h6, 4'h5, 4'h5, 4'hF};
  logic         mfl [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  logic [12:0]  ofl [4] = '{13'h0000, 13'h0000, 13'h0001, 13'h1FFF};
  int miscompares = 0, comparisons = 0, nkeys;

  always #5 clk = ~clk;

  acl_key_field_builder acl_key_field_builder_i (
    .CLK(clk), .RESET_N(rst_n), .KEY_REQ(req), .KEY_TYPE(ktype), .COMMON_FIELDS(common),
    .IS_IPV6(is_v6), .MORE_FRAGMENTS(mf), .FRAG_OFFSET(fofs), .HEADER_LEN(hlen), .TTL(ttl),
    .TYPE_OF_SERVICE(tos), .IPV4_SRC_ADDR(s4), .IPV4_DEST_ADDR(d4), .IPV6_SRC_ADDR(s6),
    .IPV6_DEST_ADDR(d6), .IP_PROTOCOL_NUMBER(proto), .POST_HEADER_BYTES(pay), .IS_PTP(is_ptp),
    .TRANSPORT_SRC_PORT(sp), .TRANSPORT_DST_PORT(dp), .RANGE_MATCH_MASK(rng), .TCP_SEQ_ZERO(seq0),
    .TCP_FIN_FLAG(fin), .TCP_SYN_FLAG(syn), .TCP_RST_FLAG(rst), .TCP_PSH_FLAG(psh), .TCP_ACK_FLAG(ack),
    .TCP_URG_FLAG(urg), .PTP_MSG_TYPE(mtype), .PTP_FLAG_FIELD(pflag), .PTP_DOMAIN(pdom),
    .PTP_VERSION(pver), .DEST_MAC(dmac), .SRC_MAC(smac), .ETHERTYPE(et), .MAINTENANCE_LEVEL(maintenance_level),
    .OAM_VERSION_FIELD(over), .FIELD_A(fa), .FIELD_B(fb), .ENDPOINT_IDENTIFIER(mep),
    .TX_FRAME_COUNT_FWD(c1), .RX_FRAME_COUNT_BACK(c2), .TX_FRAME_COUNT_BACK(c3),
    .KEY_VALID(kv), .KEY_TYPE_OUT(kto), .KEY(key), .KEY_MASK(kmask));

  key_sink key_sink_i (.clk(clk), .reset_n(rst_n), .key_valid(kv), .key(key), .key_mask(kmask),
    .key_count(nkeys), .last_key(last_key));

  task automatic chk(input string what, input logic [187:0] seen, input logic [187:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle request, key looked at one cycle later
  task automatic send(input logic [1:0] t);
    @(negedge clk);
    req = 1'b1;
    ktype = t;
    @(negedge clk);
    req = 1'b0;
    chk("valid", kv, 188'h1);
    chk("type", kto, t);
  endtask

  task automatic finish_test();
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    miscompares++;
    finish_test();
  end

  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk("reset key", key, 188'h0);
    // plain tcp over ipv4
    common = 46'h2A5A5A5A5A5A; ttl = 8'h40; tos = 8'hB8; d4 = 32'hC0A80001; s4 = 32'h0A000002;
    proto = 8'h06; dp = 16'h0050; sp = 16'h0050; rng = 8'h3C;
    seq0 = 1; syn = 1; psh = 1; urg = 1;
    send(2'd0);
    chk("common", key[45:0], common);
    chk("l3 flags", key[50:46], 5'h11);
    chk("tos", key[58:51], tos);
    chk("addr", key[122:59], {s4, d4});
    chk("eq tcp", key[124:123], 2'h2);
    chk("ports", key[164:125], {rng, sp, dp});
    chk("tcp flags", key[172:165], 8'hAB);
    chk("ptp off", key[184:173], 12'h000);
    chk("mask", kmask, {3'h0, {185{1'b1}}});
    // ptp over udp replaces flag meanings
    is_ptp = 1; mtype = 4'hC; pflag = 8'h84; pdom = 8'h5A; pver = 4'h2; proto = 8'h11; sp = 16'h013F;
    send(2'd0);
    chk("ptp bits", key[172:165], 8'hD8);
    chk("ptp dom", key[180:173], pdom);
    chk("ptp ver", key[184:181], pver);
    chk("not tcp", key[124], 1'b0);
    // options and fragment cases, layer-4 goes don't-care except for a first fragment
    for (int i = 0; i < 4; i++) begin
      hlen = hl[i]; mf = mfl[i]; fofs = ofl[i];
      send(2'd0);
      chk("frag bits", key[49:47], fexp[i]);
      chk("l4 mask", kmask[184:125], (fexp[i][2] | fexp[i][1]) ? 60'h0 : {60{1'b1}});
      if (fexp[i][2] | fexp[i][1]) chk("l4 value", key[184:125], 60'h0);
    end
    // ipv4 other key
    hlen = 4'h5; mf = 0; fofs = 0; ttl = 0; proto = 8'h2F; pay = 56'h0123456789ABCD;
    s4 = 32'h0A0B0C0D; d4 = 32'h0A0B0C0D;
    send(2'd1);
    chk("ttl zero", key[50], 1'b0);
    chk("eq4", key[123], 1'b1);
    chk("proto pay", key[187:124], {pay, proto});
    chk("other mask", kmask[187:124], {64{1'b1}});
    // ipv6 frame in the ipv4 other key
    is_v6 = 1; hlen = 4'h6; s4 = 32'h1; d4 = 32'h2;
    s6 = 128'h20010DB8_11223344_55667788_99AABBCC; d6 = s6 ^ {1'b1, 127'h0};
    send(2'd1);
    chk("v6 flags", {key[49], key[46]}, 2'h0);
    chk("v6 low src", key[122:59], {s6[31:0], s6[63:32]});
    chk("v6 differ", key[123], 1'b0);
    d6 = s6;
    send(2'd1);
    chk("v6 equal", key[123], 1'b1);
    // standard ipv6 key, requests back to back
    proto = 8'h3A;
    @(negedge clk);
    req = 1; ktype = 2'd2; ttl = 8'h01;
    @(negedge clk);
    ttl = 8'h00;
    chk("b2b valid", kv, 1'b1);
    chk("v6 key", key[182:46], {proto, s6, 1'b1});
    chk("v6 mask", kmask, {5'h0, {183{1'b1}}});
    @(negedge clk);
    req = 0;
    chk("hop zero", {kv, key[46]}, 2'h2);
    @(negedge clk);
    chk("hold", {kv, key[46], kto}, 4'h2);
    // oam key, every maintenance level
    is_v6 = 0; dmac = 48'h0180C2000030; smac = 48'h02AABBCCDDEE; over = 5'h15;
    fa = 8'h2F; fb = 8'hC3; mep = 16'hBEEF;
    for (int i = 0; i < 8; i++) begin
      maintenance_level = i[2:0];
      therm = 7'((8'h01 << i) - 8'h01);
      c1 = (i == 3) ? 32'h1 : 32'h0;
      c2 = (i == 5) ? 32'h80000000 : 32'h0;
      c3 = (i == 6) ? 32'h00010000 : 32'h0;
      et = i[0] ? 16'h8902 : 16'h8100;
      send(2'd3);
      chk("oam fields", key[185:46], {mep, fb, fa, over, therm, smac, dmac});
      chk("oam cnt et", key[187:186], {i[0], !(i == 3 || i == 5 || i == 6)});
      chk("oam mask", kmask, {188{1'b1}});
    end
    // sink counts one edge after the key appears
    @(negedge clk);
    chk("key count", nkeys, 188'd19);
    chk("sink key", last_key, {2'b11, mep, fb, fa, over, 7'h7F, smac, dmac, common});
    // reset in mid-run clears the outputs
    rst_n = 0;
    #1;
    chk("mid reset", {kv, kto, key}, 191'h0);
    @(negedge clk);
    rst_n = 1'b1;
    send(2'd2);
    chk("after reset", key[182:46], {proto, s6, 1'b0});
    finish_test();
  end
endmodule // testbench
